// ===== hdl/ifch_handler.sv
// ISP frame command handler: decodes frames, runs read and blank check
`timescale 1ns/1ps
`include "ifch_defs.svh"
module ifch_handler
   import ifch_pkg::*;
#(
   parameter logic [7:0] BOOT_REV = 8'h10,    // Arbitrary value
   parameter logic [7:0] BOOT_ID1 = 8'h11,    // Arbitrary value
   parameter logic [7:0] BOOT_ID2 = 8'h12,    // Arbitrary value
   parameter logic [7:0] SIG_MANUF = 8'hA5,   // Arbitrary value
   parameter logic [7:0] SIG_FAMILY = 8'h5A,  // Arbitrary value
   parameter logic [7:0] SIG_PRODUCT = 8'h3C, // Arbitrary value
   parameter logic [7:0] SIG_REV = 8'hC3      // Arbitrary value
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic rx_valid,
   input wire logic rx_first,
   input wire logic [7:0] rx_byte,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic tx_kind_addr,
   output logic [16:0] tx_addr,
   output logic flash_rd,
   output logic [16:0] flash_addr,
   input wire logic [7:0] flash_data,
   input wire logic [7:0] security_level_byte,
   input wire logic [7:0] boot_config_byte,
   output logic wdog_reset,
   output logic [1:0] family_page,
   output logic [3:0] family_sel
);
   // ==========================================
   // Frame capture
   // Frame bytes arrive as length, offset hi, offset lo, type, data..., checksum
   ifch_state_e state_reg;
   logic [7:0] len_reg, type_reg, sum_reg;
   logic [15:0] off_reg;
   logic [7:0] dat_reg [0:4];
   logic [7:0] cnt_reg;
   logic [16:0] cur_reg, end_reg;
   logic is_blank_reg;
   logic [2:0] lvl;
   logic lvl_ok;
   logic [7:0] info_byte;
   logic info_hit;
   logic [7:0] sum_next;

   assign lvl = security_level_byte[2:0];
   assign lvl_ok = (lvl == `IFCH_LVL_NONE) || (lvl == `IFCH_LVL_TWO);
   assign sum_next = sum_reg + rx_byte;

   always_comb begin
      info_byte = 8'h00;
      info_hit = 1'b0;
      if (family_sel == `IFCH_FAM_SEC && dat_reg[1] == 8'h00 && dat_reg[0] == 8'h00) begin
         info_byte = security_level_byte;
         info_hit = 1'b1;
      end else if (family_sel == `IFCH_FAM_CONF && dat_reg[1] == 8'h00 && dat_reg[0] == 8'h00) begin
         info_byte = boot_config_byte;
         info_hit = 1'b1;
      end else if (family_sel == `IFCH_FAM_BOOT && dat_reg[0] == 8'h00) begin
         info_hit = 1'b1;
         if (dat_reg[1] == `IFCH_BOOT_REV) begin
            info_byte = BOOT_REV;
         end else if (dat_reg[1] == `IFCH_BOOT_ID1) begin
            info_byte = BOOT_ID1;
         end else if (dat_reg[1] == `IFCH_BOOT_ID2) begin
            info_byte = BOOT_ID2;
         end else begin
            info_hit = 1'b0;
         end
      end else if (family_sel == `IFCH_FAM_SIG && dat_reg[0] == 8'h00) begin
         info_hit = 1'b1;
         if (dat_reg[1] == `IFCH_SIG_MANUF) begin
            info_byte = SIG_MANUF;
         end else if (dat_reg[1] == `IFCH_SIG_FAMILY) begin
            info_byte = SIG_FAMILY;
         end else if (dat_reg[1] == `IFCH_SIG_PRODUCT) begin
            info_byte = SIG_PRODUCT;
         end else if (dat_reg[1] == `IFCH_SIG_REV) begin
            info_byte = SIG_REV;
         end else begin
            info_hit = 1'b0;
         end
      end
   end

   // ==========================================
   // Main sequencer
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_reg <= IFCH_IDLE;
         len_reg <= 8'h00;
         type_reg <= 8'h00;
         sum_reg <= 8'h00;
         off_reg <= 16'h0000;
         cnt_reg <= 8'h00;
         cur_reg <= 17'h00000;
         end_reg <= 17'h00000;
         is_blank_reg <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            dat_reg[i] <= 8'h00;
         end
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
         tx_kind_addr <= 1'b0;
         tx_addr <= 17'h00000;
         flash_rd <= 1'b0;
         flash_addr <= 17'h00000;
         wdog_reset <= 1'b0;
         family_page <= 2'h0;
         family_sel <= `IFCH_FAM_FLASH;
      end else if (clk_en) begin
         flash_rd <= 1'b0;
         if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
         end
         case (state_reg)
            IFCH_IDLE: begin
               if (rx_valid && rx_first) begin
                  len_reg <= rx_byte;
                  sum_reg <= rx_byte;
                  cnt_reg <= 8'h01;
                  state_reg <= IFCH_HDR;
               end
            end
            IFCH_HDR: begin
               if (rx_valid) begin
                  sum_reg <= sum_next;
                  cnt_reg <= cnt_reg + 8'h01;
                  if (cnt_reg == 8'h01) begin
                     off_reg[15:8] <= rx_byte;
                  end else if (cnt_reg == 8'h02) begin
                     off_reg[7:0] <= rx_byte;
                  end else begin
                     type_reg <= rx_byte;
                     cnt_reg <= 8'h00;
                     state_reg <= IFCH_DATA;
                  end
               end
            end
            IFCH_DATA: begin
               if (rx_valid) begin
                  sum_reg <= sum_next;
                  cnt_reg <= cnt_reg + 8'h01;
                  if (cnt_reg < 8'h05) begin
                     dat_reg[cnt_reg[2:0]] <= rx_byte;
                  end
                  // Final byte is the checksum; total must wrap to zero
                  if (cnt_reg == len_reg) begin
                     state_reg <= IFCH_EXEC;
                     if (sum_next != 8'h00) begin
                        tx_byte <= `IFCH_CH_X;
                        tx_kind_addr <= 1'b0;
                        tx_valid <= 1'b1;
                        state_reg <= IFCH_REPLY;
                     end
                  end
               end
            end
            IFCH_EXEC: begin
               state_reg <= IFCH_IDLE;
               cur_reg <= {family_page[0], dat_reg[0], dat_reg[1]};
               end_reg <= {family_page[0], dat_reg[2], dat_reg[3]};
               if (type_reg == `IFCH_REC_START && len_reg == `IFCH_LEN_START && off_reg == 16'h0000) begin
                  wdog_reset <= 1'b1;
               end else if (type_reg == `IFCH_REC_PAGE && len_reg == `IFCH_LEN_PAGE) begin
                  if (family_sel == `IFCH_FAM_FLASH && dat_reg[0][7:4] < 4'h2) begin
                     family_page <= {1'b0, dat_reg[0][4]};
                     tx_byte <= `IFCH_CH_DOT;
                     tx_valid <= 1'b1;
                     state_reg <= IFCH_REPLY;
                  end
               end else if (type_reg == `IFCH_REC_CMD && len_reg == `IFCH_LEN_SELMEM && off_reg == 16'h0000) begin
                  if ((dat_reg[0] == 8'h00 && dat_reg[1] < 8'h02) ||
                      ((dat_reg[0] == 8'h03 || dat_reg[0] == 8'h06 || dat_reg[0] == 8'h07 ||
                        dat_reg[0] == 8'h08) && dat_reg[1] == 8'h00)) begin
                     family_sel <= dat_reg[0][3:0];
                     family_page <= dat_reg[1][1:0];
                     tx_byte <= `IFCH_CH_DOT;
                     tx_valid <= 1'b1;
                     state_reg <= IFCH_REPLY;
                  end // else
               end else if (type_reg == `IFCH_REC_CMD && len_reg == `IFCH_LEN_RANGE && off_reg == 16'h0000) begin
                  if (dat_reg[4] == `IFCH_ACT_BLANK && family_sel == `IFCH_FAM_FLASH) begin
                     if (!lvl_ok) begin
                        tx_byte <= `IFCH_CH_L;
                        tx_valid <= 1'b1;
                        state_reg <= IFCH_REPLY;
                     end else begin
                        is_blank_reg <= 1'b1;
                        state_reg <= IFCH_MEMRD;
                     end
                  end else if (dat_reg[4] == `IFCH_ACT_READ && family_sel == `IFCH_FAM_FLASH) begin
                     if (!lvl_ok) begin
                        tx_byte <= `IFCH_CH_L;
                        tx_valid <= 1'b1;
                        state_reg <= IFCH_REPLY;
                     end else begin
                        is_blank_reg <= 1'b0;
                        state_reg <= IFCH_MEMRD;
                     end
                  end else if (dat_reg[4] == `IFCH_ACT_READ && info_hit) begin
                     tx_byte <= info_byte;
                     tx_kind_addr <= 1'b1;
                     tx_addr <= {9'h000, dat_reg[1]};
                     tx_valid <= 1'b1;
                     state_reg <= IFCH_REPLY;
                  end
               end
            end
            IFCH_MEMRD: begin
               // Flash data stands one cycle only, so no read starts while a byte is still offered
               if (!tx_valid) begin
                  flash_rd <= 1'b1;
                  flash_addr <= cur_reg;
                  state_reg <= IFCH_MEMWT;
               end
            end
            IFCH_MEMWT: begin
               if (!flash_rd && !tx_valid) begin
                  if (is_blank_reg) begin
                     if (flash_data != `IFCH_ERASED) begin
                        tx_kind_addr <= 1'b1;
                        tx_addr <= cur_reg;
                        tx_byte <= `IFCH_ERASED;
                        tx_valid <= 1'b1;
                        state_reg <= IFCH_REPLY;
                     end else if (cur_reg >= end_reg || cur_reg == `IFCH_FLASH_TOP) begin
                        tx_kind_addr <= 1'b0;
                        tx_byte <= `IFCH_CH_DOT;
                        tx_valid <= 1'b1;
                        state_reg <= IFCH_REPLY;
                     end else begin
                        cur_reg <= cur_reg + 17'h00001;
                        state_reg <= IFCH_MEMRD;
                     end
                  end else begin
                     tx_kind_addr <= 1'b1;
                     tx_addr <= cur_reg;
                     tx_byte <= flash_data;
                     tx_valid <= 1'b1;
                     if (cur_reg >= end_reg || cur_reg == `IFCH_FLASH_TOP) begin
                        state_reg <= IFCH_REPLY;
                     end else begin
                        cur_reg <= cur_reg + 17'h00001;
                        state_reg <= IFCH_MEMRD;
                     end
                  end
               end
            end
            IFCH_REPLY: begin
               // Reply ends when the last item is accepted; the serialiser adds CR LF
               if (tx_valid && tx_ready) begin
                  tx_kind_addr <= 1'b0;
                  state_reg <= IFCH_IDLE;
               end
            end
            default: state_reg <= IFCH_IDLE;
         endcase
      end
   end

   // ==========================================
   // Checks
   chk_level_gate: assert property (@(posedge mclk) disable iff (!nrst)
      flash_rd |-> lvl_ok) else $error("Flash read at forbidden level");
   chk_bad_sum: assert property (@(posedge mclk) disable iff (!nrst)
      (clk_en && state_reg == IFCH_DATA && rx_valid && cnt_reg == len_reg && sum_next != 8'h00)
      |=> (tx_valid && tx_byte == `IFCH_CH_X)) else $error("Bad checksum not answered");
   chk_blank_fam: assert property (@(posedge mclk) disable iff (!nrst)
      (state_reg == IFCH_MEMRD) |-> family_sel == `IFCH_FAM_FLASH) else $error("Flash op on other family");
   chk_range: assert property (@(posedge mclk) disable iff (!nrst)
      flash_rd |-> flash_addr <= `IFCH_FLASH_TOP) else $error("Flash address out of range");
   chk_page_legal: assert property (@(posedge mclk) disable iff (!nrst)
      family_sel != `IFCH_FAM_FLASH |-> family_page == 2'h0) else $error("Page on non-flash family");
   chk_start_app: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(wdog_reset) |-> $past(state_reg) == IFCH_EXEC && $past(type_reg) == `IFCH_REC_START)
      else $error("Watchdog without start frame");
   chk_refuse_l: assert property (@(posedge mclk) disable iff (!nrst)
      (clk_en && state_reg == IFCH_EXEC && type_reg == `IFCH_REC_CMD && len_reg == `IFCH_LEN_RANGE &&
       off_reg == 16'h0000 && family_sel == `IFCH_FAM_FLASH && !lvl_ok && dat_reg[4] == `IFCH_ACT_READ)
      |=> tx_byte == `IFCH_CH_L) else $error("Secured read not refused");
   chk_fail_addr: assert property (@(posedge mclk) disable iff (!nrst)
      (clk_en && state_reg == IFCH_MEMWT && !flash_rd && !tx_valid && is_blank_reg && flash_data != `IFCH_ERASED)
      |=> tx_kind_addr && tx_addr == $past(cur_reg)) else $error("Blank fail address wrong");
   cov_blank: cover property (@(posedge mclk) state_reg == IFCH_MEMWT && is_blank_reg);
   cov_secure: cover property (@(posedge mclk) tx_valid && tx_byte == `IFCH_CH_L);
   cov_wdog: cover property (@(posedge mclk) $rose(wdog_reset));
endmodule // ifch_handler

// ===== pkg/ifch_defs.svh
// Constants for the ISP frame command handler
//==========================================
`ifndef IFCH_DEFS_SVH
`define IFCH_DEFS_SVH
`define IFCH_REC_PROGRAM 8'h00
`define IFCH_REC_START 8'h01
`define IFCH_REC_PAGE 8'h02
`define IFCH_REC_CMD 8'h04
`define IFCH_LEN_START 8'h00
`define IFCH_LEN_PAGE 8'h02
`define IFCH_LEN_SELMEM 8'h02
`define IFCH_LEN_RANGE 8'h05
`define IFCH_ACT_READ 8'h00
`define IFCH_ACT_BLANK 8'h01
`define IFCH_ACT_ERASE 8'h02
`define IFCH_FAM_FLASH 4'h0
`define IFCH_FAM_BOOT 4'h3
`define IFCH_FAM_SIG 4'h6
`define IFCH_FAM_SEC 4'h7
`define IFCH_FAM_CONF 4'h8
`define IFCH_FLASH_TOP 17'h1FFFF
`define IFCH_LVL_NONE 3'h7
`define IFCH_LVL_TWO 3'h6
`define IFCH_BOOT_REV 8'h00
`define IFCH_BOOT_ID1 8'h01
`define IFCH_BOOT_ID2 8'h02
`define IFCH_SIG_MANUF 8'h30
`define IFCH_SIG_FAMILY 8'h31
`define IFCH_SIG_PRODUCT 8'h60
`define IFCH_SIG_REV 8'h61
`define IFCH_CH_X 8'h58
`define IFCH_CH_L 8'h4C
`define IFCH_CH_DOT 8'h2E
`define IFCH_CH_CR 8'h0D
`define IFCH_CH_LF 8'h0A
`define IFCH_ERASED 8'hFF
`endif

// ===== pkg/ifch_pkg.sv
// Types for the ISP frame command handler
package ifch_pkg;
   typedef enum logic [6:0] {
      IFCH_IDLE = 7'h01,
      IFCH_HDR = 7'h02,
      IFCH_DATA = 7'h04,
      IFCH_EXEC = 7'h08,
      IFCH_MEMRD = 7'h10,
      IFCH_MEMWT = 7'h20,
      IFCH_REPLY = 7'h40
   } ifch_state_e;
   typedef enum logic [1:0] {
      IFCH_RP_CHAR = 2'h0,
      IFCH_RP_DATA = 2'h1,
      IFCH_RP_ADDR = 2'h2
   } ifch_reply_e;
endpackage

// ===== tb/ifch_far_model.sv
// Far-side model: flash array behind the handler and the reply serialiser
`timescale 1ns/1ps
module ifch_far_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic flash_rd,
   input wire logic [16:0] flash_addr,
   output logic [7:0] flash_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] mem [int];
   logic [7:0] data_reg = 8'h5A;
   logic [1:0] pace_reg = 2'h0;
   logic ready_reg = 1'b0;
   assign flash_data = data_reg;
   assign tx_ready = ready_reg;
   //==========================================
   // Flash array, unwritten cells read as erased
   // Data stands one cycle only, then the bus churns so stale bytes cannot pass
   always @(posedge mclk) begin
      if (flash_rd === 1'b1) begin
         data_reg <= mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 8'hFF;
      end else begin
         data_reg <= ~data_reg;
      end
   end
   //==========================================
   // Serialiser acceptance, ready one cycle in four while slow
   always @(posedge mclk) begin
      pace_reg <= nrst ? pace_reg + 2'h1 : 2'h0;
      ready_reg <= nrst && (!slow || pace_reg == 2'h3);
   end
endmodule // ifch_far_model

// ===== tb/tb_top.sv
// Self-checking bench for the ISP frame command handler
`timescale 1ns/1ps
`include "ifch_defs.svh"
module tb_top;
   localparam logic [7:0] BOOT_V [3] = '{8'h21, 8'h22, 8'h23};
   localparam logic [7:0] SIG_A [4] = '{8'h30, 8'h31, 8'h60, 8'h61};
   localparam logic [7:0] SIG_V [4] = '{8'h41, 8'h42, 8'h43, 8'h44};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_first = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic slow = 1'b0;
   logic clk_en = 1'b1;
   logic [1:0] fam_page;
   logic [3:0] fam_sel;
   logic [7:0] sec_byte = 8'hFF;
   logic [7:0] conf_byte = 8'h96;
   logic tx_ready, tx_valid, tx_kind_addr, flash_rd, wdog_reset;
   logic [7:0] tx_byte, flash_data;
   logic [16:0] tx_addr, flash_addr;
   int miscompares = 0;
   int cmp_count = 0;
   int rd_count = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (flash_rd === 1'b1) rd_count++;
   end
   ifch_handler #(.BOOT_REV(BOOT_V[0]), .BOOT_ID1(BOOT_V[1]), .BOOT_ID2(BOOT_V[2]), .SIG_MANUF(SIG_V[0]),
      .SIG_FAMILY(SIG_V[1]), .SIG_PRODUCT(SIG_V[2]), .SIG_REV(SIG_V[3])) dut (.mclk(mclk), .nrst(nrst),
      .clk_en(clk_en), .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_kind_addr(tx_kind_addr), .tx_addr(tx_addr),
      .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_data(flash_data), .security_level_byte(sec_byte),
      .boot_config_byte(conf_byte), .wdog_reset(wdog_reset), .family_page(fam_page), .family_sel(fam_sel));
   ifch_far_model far (.mclk(mclk), .nrst(nrst), .slow(slow), .flash_rd(flash_rd), .flash_addr(flash_addr),
      .flash_data(flash_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   //==========================================
   // Shared tasks
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   // Checksum makes the byte sum zero; bad flips its low bit
   task automatic send(input logic [7:0] typ, input logic [15:0] off, input int n, input logic [39:0] d,
         input logic bad);
      logic [7:0] q [$];
      logic [7:0] sum;
      q = {8'(n), off[15:8], off[7:0], typ};
      for (int j = 0; j < n; j++) q.push_back(d[39-8*j -: 8]);
      sum = 8'h00;
      foreach (q[i]) sum += q[i];
      q.push_back((8'h00 - sum) ^ {7'h00, bad});
      foreach (q[i]) begin
         rx_valid <= 1'b1;
         rx_first <= (i == 0);
         rx_byte <= q[i];
         @(posedge mclk);
      end
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
   endtask
   task automatic take(output logic k, output logic [16:0] a, output logic [7:0] b);
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge mclk);
         if (tx_valid === 1'b1 && tx_ready === 1'b1) break;
      end
      if (i == 400) begin
         $display("CHECK FAILED reply expected item seen none");
         miscompares++;
         end_of_test();
      end
      k = tx_kind_addr;
      a = tx_addr;
      b = tx_byte;
      @(posedge mclk);
   endtask
   task automatic exp_char(input string what, input logic [7:0] c);
      logic k;
      logic [16:0] a;
      logic [7:0] b;
      take(k, a, b);
      check({what, " kind"}, 32'h0, 32'(k));
      check(what, 32'(c), 32'(b));
   endtask
   task automatic exp_item(input string what, input logic [16:0] ea, input logic [7:0] eb);
      logic k;
      logic [16:0] a;
      logic [7:0] b;
      take(k, a, b);
      check({what, " kind"}, 32'h1, 32'(k));
      check({what, " addr"}, 32'(ea), 32'(a));
      check(what, 32'(eb), 32'(b));
   endtask
   task automatic no_reply(input string what);
      logic seen;
      seen = 1'b0;
      repeat (60) begin
         @(negedge mclk);
         if (tx_valid !== 1'b0) seen = 1'b1;
      end
      check(what, 32'h0, 32'(seen));
      @(posedge mclk);
   endtask
   task automatic sel(input logic [7:0] fam, input logic [7:0] pg);
      send(8'h04, 16'h0000, 2, {fam, pg, 24'h0}, 1'b0);
   endtask
   task automatic rd(input logic [15:0] s, input logic [15:0] e, input logic [7:0] act);
      send(8'h04, 16'h0000, 5, {s, e, act}, 1'b0);
   endtask
   //==========================================
   // Scenarios
   task automatic t_checksum;
      sel(8'h00, 8'h00);
      exp_char("select ack", `IFCH_CH_DOT);
      send(8'h04, 16'h0000, 5, {32'h0, 8'h00}, 1'b1);
      // A low enable must freeze the pending reply even though the serialiser is ready
      clk_en <= 1'b0;
      repeat (5) @(posedge mclk);
      check("frozen reply", 32'h1, 32'(tx_valid));
      clk_en <= 1'b1;
      exp_char("bad checksum", `IFCH_CH_X);
      check("reads after bad frame", 32'h0, 32'(rd_count));
      $display("Test checksum done");
   endtask
   task automatic t_security;
      sec_byte <= 8'hFD;
      rd(16'h0000, 16'h0003, `IFCH_ACT_READ);
      exp_char("read refused", `IFCH_CH_L);
      sec_byte <= 8'hFB;
      rd(16'h0000, 16'h0003, `IFCH_ACT_BLANK);
      exp_char("blank refused", `IFCH_CH_L);
      check("reads while refused", 32'h0, 32'(rd_count));
      $display("Test security done");
   endtask
   task automatic t_blank;
      sec_byte <= 8'hFE;
      far.mem[32'h10005] = 8'h00;
      far.mem[32'h1FFFF] = 8'h12;
      sel(8'h00, 8'h01);
      exp_char("page ack", `IFCH_CH_DOT);
      rd(16'h0000, 16'h000F, `IFCH_ACT_BLANK);
      exp_item("blank first fail", 17'h10005, `IFCH_ERASED);
      rd(16'h0000, 16'h0004, `IFCH_ACT_BLANK);
      exp_char("blank pass", `IFCH_CH_DOT);
      rd(16'hFFFE, 16'hFFFF, `IFCH_ACT_BLANK);
      exp_item("blank top", `IFCH_FLASH_TOP, `IFCH_ERASED);
      sel(8'h00, 8'h00);
      exp_char("page0 select", `IFCH_CH_DOT);
      send(8'h02, 16'h0000, 2, {8'h10, 8'h00, 24'h0}, 1'b0);
      exp_char("new page ack", `IFCH_CH_DOT);
      check("page reg", 32'h1, 32'(fam_page));
      rd(16'h0005, 16'h0005, `IFCH_ACT_BLANK);
      exp_item("blank upper page", 17'h10005, `IFCH_ERASED);
      $display("Test blank done");
   endtask
   task automatic t_read;
      slow <= 1'b1;
      sec_byte <= 8'hFF;
      far.mem[32'h00000] = 8'hA1;
      far.mem[32'h00001] = 8'hB2;
      sel(8'h00, 8'h00);
      exp_char("page0 ack", `IFCH_CH_DOT);
      rd(16'h0000, 16'h0001, `IFCH_ACT_READ);
      exp_item("flash byte0", 17'h00000, 8'hA1);
      exp_item("flash byte1", 17'h00001, 8'hB2);
      slow <= 1'b0;
      $display("Test read done");
   endtask
   task automatic t_families;
      int n;
      sec_byte <= 8'hFB;
      sel(8'h07, 8'h00);
      exp_char("sec ack", `IFCH_CH_DOT);
      check("family reg", 32'h7, 32'(fam_sel));
      rd(16'h0000, 16'h0000, `IFCH_ACT_READ);
      exp_item("security byte", 17'h0, 8'hFB);
      sel(8'h08, 8'h00);
      exp_char("conf ack", `IFCH_CH_DOT);
      rd(16'h0000, 16'h0000, `IFCH_ACT_READ);
      exp_item("config byte", 17'h0, conf_byte);
      n = rd_count;
      rd(16'h0000, 16'h0000, `IFCH_ACT_BLANK);
      no_reply("blank off flash");
      check("flash reads off flash", 32'(n), 32'(rd_count));
      sel(8'h03, 8'h00);
      exp_char("boot ack", `IFCH_CH_DOT);
      for (int i = 0; i < 3; i++) begin
         rd(16'(i), 16'(i), `IFCH_ACT_READ);
         exp_item("boot info", 17'(i), BOOT_V[i]);
      end
      sel(8'h06, 8'h00);
      exp_char("sig ack", `IFCH_CH_DOT);
      for (int i = 0; i < 4; i++) begin
         rd({8'h00, SIG_A[i]}, {8'h00, SIG_A[i]}, `IFCH_ACT_READ);
         exp_item("signature", {9'h0, SIG_A[i]}, SIG_V[i]);
      end
      $display("Test families done");
   endtask
   task automatic t_undefined;
      sel(8'h05, 8'h00);
      no_reply("undefined family");
      check("family kept", 32'h6, 32'(fam_sel));
      send(8'h00, 16'h0010, 1, {8'hAA, 32'h0}, 1'b0);
      no_reply("program frame");
      sel(8'h00, 8'h02);
      no_reply("undefined page");
      rd(16'h0005, 16'h0005, `IFCH_ACT_READ);
      no_reply("undefined address");
      $display("Test undefined done");
   endtask
   task automatic t_start;
      conf_byte <= 8'h97;
      send(8'h01, 16'h0000, 0, 40'h0, 1'b0);
      no_reply("start reply");
      check("watchdog reset", 32'h1, 32'(wdog_reset));
      $display("Test start done");
   endtask
   //==========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      check("idle watchdog", 32'h0, 32'(wdog_reset));
      t_checksum();
      t_security();
      t_blank();
      t_read();
      t_families();
      t_undefined();
      t_start();
      end_of_test();
   end
endmodule // tb_top
